// >>> common/stk_params.svh
// Purpose: Constants for the system tick down-counter.
// Assumes: Byte addresses on a 32-bit register port, 100 MHz clock.
// Notes: Definitions only.
`ifndef STK_PARAMS_SVH
`define STK_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STK_OFS_CTRL 12'h010
`define STK_OFS_RELOAD 12'h014
`define STK_OFS_CURRENT 12'h018
`define STK_OFS_CALIB 12'h01c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STK_BIT_ENABLE 0
`define STK_BIT_EXC_EN 1
`define STK_BIT_SRC_SEL 2
`define STK_BIT_WRAP 16
`define STK_CALIB_NOREF 31
`define STK_CALIB_SKEW 30

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define STK_CTRL_RESET 3'h0
`define STK_CNT_RESET 24'h000000
`define STK_REF_DIV 32
`define STK_CALIB_TENMS 24'h000000

`endif

// >>> common/stk_pkg.sv
// Purpose: Types for the system tick down-counter.
// Assumes: Nothing beyond the params header.
// Notes: Register selection is one-hot.
package stk_pkg;
  typedef enum logic [4:0] {
    STK_SEL_NONE = 5'h01,
    STK_SEL_CTRL = 5'h02,
    STK_SEL_RELOAD = 5'h04,
    STK_SEL_CURRENT = 5'h08,
    STK_SEL_CALIB = 5'h10
  } stk_sel_t;
endpackage

// >>> verilog/stk_ref_div.sv
// Purpose: Reference tick generator, one pulse every DIV oscillator cycles.
// Assumes: Oscillator edges arrive as a one-cycle enable on sys_clk.
// Notes: Default DIV is 32.
`timescale 1ns/100ps
`include "stk_params.svh"
module stk_ref_div #(
  parameter int DIV = `STK_REF_DIV
) (
  input wire logic sys_clk, // System clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic oscEn, // One pulse per oscillator cycle.
  output logic refTick // One pulse per DIV oscillator cycles.
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q;

  if (DIV < 2) begin : g_bad_div
    $error("DIV must be at least 2.");
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      refTick <= 1'b0;
    end else begin
      refTick <= 1'b0;
      if (oscEn) begin
        if (cnt_q == CW'(DIV - 1)) begin
          cnt_q <= '0;
          refTick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule // stk_ref_div

// >>> verilog/stk_timer.sv
// Purpose: 24-bit system tick down-counter with its four registers.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes: Tick exception request is a one-cycle pulse on each wrap while the exception enable bit is set.
`timescale 1ns/100ps
`include "stk_params.svh"

module stk_timer
  import stk_pkg::*;
#(
  parameter int CW = 24
) (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic oscEn, // Oscillator cycle enable pulse.
  input wire logic [11:0] regAddr, // Register byte address.
  input wire logic [31:0] regWdata, // Write data.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  output logic [31:0] regRdata, // Read data, valid the cycle after regRd.
  output logic tickExcReq // Tick exception request pulse.
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // The read mux and the field macros assume a 24-bit count, so other widths are refused.
  if (CW != 24) begin : g_bad_width
    $error("Counter width must be 24.");
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic stk_sel_t decode(input logic [11:0] a);
    case (a)
      `STK_OFS_CTRL: decode = STK_SEL_CTRL;
      `STK_OFS_RELOAD: decode = STK_SEL_RELOAD;
      `STK_OFS_CURRENT: decode = STK_SEL_CURRENT;
      `STK_OFS_CALIB: decode = STK_SEL_CALIB;
      default: decode = STK_SEL_NONE;
    endcase
  endfunction

  stk_sel_t sel;
  assign sel = decode(regAddr);

  logic enable_q;
  logic excEn_q;
  logic srcSel_q;
  logic wrap_q;
  logic [CW-1:0] reload_q;
  logic [CW-1:0] count_q;
  logic refTick;
  logic tick;
  logic atZero;
  logic wrapEv;
  logic startEv;
  logic clrWr;
  logic ctrlRd;

  stk_ref_div #(
    .DIV(`STK_REF_DIV)
  ) u_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .oscEn(oscEn),
    .refTick(refTick)
  );

  assign tick = srcSel_q ? 1'b1 : refTick;
  assign atZero = (count_q == '0);
  assign startEv = regWr && (sel == STK_SEL_CTRL) && regWdata[`STK_BIT_ENABLE] && !enable_q;
  assign clrWr = regWr && (sel == STK_SEL_CURRENT);
  assign ctrlRd = regRd && (sel == STK_SEL_CTRL);
  // The wrap is the step that finds zero and reloads.
  assign wrapEv = enable_q && tick && atZero && !clrWr && !startEv;

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= 1'b0;
      excEn_q <= 1'b0;
      srcSel_q <= 1'b0;
    end else if (regWr && sel == STK_SEL_CTRL) begin
      enable_q <= regWdata[`STK_BIT_ENABLE];
      excEn_q <= regWdata[`STK_BIT_EXC_EN];
      srcSel_q <= regWdata[`STK_BIT_SRC_SEL];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_q <= `STK_CNT_RESET;
    end else if (regWr && sel == STK_SEL_RELOAD) begin
      reload_q <= regWdata[CW-1:0];
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= `STK_CNT_RESET;
    end else if (clrWr) begin
      count_q <= '0;
    end else if (startEv) begin
      count_q <= reload_q;
    end else if (enable_q && tick) begin
      if (atZero) begin
        count_q <= reload_q;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Set wins over the read clear so a wrap in the read cycle is kept.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_q <= 1'b0;
    end else if (wrapEv) begin
      wrap_q <= 1'b1;
    end else if (ctrlRd || clrWr) begin
      wrap_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickExcReq <= 1'b0;
    end else begin
      tickExcReq <= wrapEv && excEn_q;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      regRdata <= 32'h00000000;
      case (sel)
        STK_SEL_CTRL: begin
          regRdata[`STK_BIT_ENABLE] <= enable_q;
          regRdata[`STK_BIT_EXC_EN] <= excEn_q;
          regRdata[`STK_BIT_SRC_SEL] <= srcSel_q;
          regRdata[`STK_BIT_WRAP] <= wrap_q || wrapEv;
        end
        STK_SEL_RELOAD: regRdata[CW-1:0] <= reload_q;
        STK_SEL_CURRENT: regRdata[CW-1:0] <= count_q;
        STK_SEL_CALIB: regRdata[CW-1:0] <= `STK_CALIB_TENMS;
        STK_SEL_NONE: regRdata <= 32'h00000000;
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_wrap;
    enable_q && tick && atZero && !clrWr && !startEv;
  endsequence

  AST_WRAP_SETS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_wrap |=> wrap_q) else $error("Wrap did not set flag.");
  AST_READ_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctrlRd && !wrapEv) |=> !wrap_q) else $error("Control read did not clear flag.");
  AST_SRC_CPU: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (srcSel_q && enable_q && !atZero && !clrWr && !startEv && !(regWr && sel == STK_SEL_CTRL))
    |=> count_q == $past(count_q) - 1'b1) else $error("CPU clock did not count.");
  AST_EXC_GATED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tickExcReq |-> $past(excEn_q) && $past(wrapEv)) else $error("Exception without cause.");
  AST_START_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (startEv && !clrWr) |=> count_q == $past(reload_q)) else $error("Enable did not load.");
  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_wrap |=> count_q == $past(reload_q)) else $error("Zero did not reload.");
  AST_CUR_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (regRd && sel == STK_SEL_CURRENT) |=> regRdata == {8'h00, $past(count_q)})
    else $error("Current read wrong.");
  AST_CUR_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clrWr |=> count_q == '0 && !wrap_q) else $error("Current write did not clear.");
  AST_DISABLED_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!enable_q && !startEv && !clrWr) |=> $stable(count_q)) else $error("Counted while off.");
  AST_CTRL_ZEROS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrlRd |=> (regRdata & 32'hfffefff8) == 32'h00000000) else $error("Reserved bits set.");

  // ----------------------------------------
  // Reference divider checker
  // ----------------------------------------
  // An independent count of oscillator pulses since the last reference tick.
  // A divider that skips or adds a pulse still counts down, so only this count sees it.
  localparam int REF_DIV = `STK_REF_DIV;
  localparam int OW = $clog2(REF_DIV + 1);
  logic [OW-1:0] oscSeen_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscSeen_q <= '0;
    end else if (refTick) begin
      oscSeen_q <= OW'(oscEn);
    end else if (oscEn) begin
      oscSeen_q <= oscSeen_q + 1'b1;
    end
  end

  AST_REF_PERIOD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    refTick |-> oscSeen_q == OW'(REF_DIV))
    else $error("Reference tick off its period.");
  AST_REF_NO_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    oscSeen_q <= OW'(REF_DIV))
    else $error("Reference tick missing.");

  // ----------------------------------------
  // Sequences for the further checks
  // ----------------------------------------
  // A control read that must return the flag set.
  sequence s_flag_read;
    ctrlRd && (wrap_q || wrapEv);
  endsequence

  // Reference source with no tick: the count must not move.
  sequence s_ref_idle;
    !srcSel_q && !refTick && !startEv && !clrWr;
  endsequence

  // Reference source with a tick above zero: one step down.
  sequence s_ref_step;
    !srcSel_q && refTick && enable_q && !atZero && !startEv && !clrWr;
  endsequence

  // A wrap that is allowed to pend the exception.
  sequence s_exc_wrap;
    s_wrap ##0 excEn_q;
  endsequence

  // Enable written again while already enabled, with no tick to move the count.
  sequence s_rearm;
    regWr && sel == STK_SEL_CTRL && enable_q && !tick;
  endsequence

  // ----------------------------------------
  // Flag checks
  // ----------------------------------------
  AST_FLAG_READ_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_flag_read |=> regRdata[`STK_BIT_WRAP])
    else $error("Flag read as zero after a wrap.");
  AST_FLAG_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wrap_q && !ctrlRd && !clrWr) |=> wrap_q)
    else $error("Flag lost without a read.");
  AST_FLAG_NO_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!wrap_q && !wrapEv) |=> !wrap_q)
    else $error("Flag set without a wrap.");

  // ----------------------------------------
  // Count and source checks
  // ----------------------------------------
  AST_REF_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_ref_idle |=> $stable(count_q))
    else $error("Count moved without a reference tick.");
  AST_REF_STEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_ref_step |=> count_q == $past(count_q) - 1'b1)
    else $error("Reference tick did not count.");
  AST_NO_REARM: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_rearm |=> $stable(count_q))
    else $error("Enable rewrite reloaded the count.");
  AST_RELOAD_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (regWr && sel == STK_SEL_RELOAD) |=> {8'h00, reload_q} == ($past(regWdata) & 32'h00ffffff))
    else $error("Reload field not stored.");

  // ----------------------------------------
  // Exception and read data checks
  // ----------------------------------------
  AST_EXC_ON_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_exc_wrap |=> tickExcReq)
    else $error("Wrap did not pend the exception.");
  AST_EXC_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wrapEv |=> !tickExcReq)
    else $error("Exception pended without a wrap.");
  AST_RELOAD_ZEROS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (regRd && sel == STK_SEL_RELOAD) |=> regRdata[31:24] == 8'h00)
    else $error("Reload upper bits set.");
  AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (regRd && sel inside {STK_SEL_NONE, STK_SEL_CALIB}) |=> regRdata == 32'h00000000)
    else $error("Empty register read not zero.");
  AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !regRd |=> regRdata == 32'h00000000)
    else $error("Read data shown without a read.");
endmodule // stk_timer

// >>> bench/stk_osc_model.sv
// Purpose: Far-side model, oscillator pulses and exception receiver.
// Assumes: Bursts are multiples of 32 so the divider phase stays known.
// Notes: Slow mode puts an idle cycle between pulses.
`timescale 1ns/100ps
module stk_osc_model (
  input wire logic sys_clk, // System clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic start, // Load a burst.
  input wire logic [15:0] burst, // Pulses to send.
  input wire logic slow, // Gap between pulses.
  input wire logic tickExcReq, // Exception pulse.
  output logic oscEn, // Oscillator pulse.
  output logic busy, // Burst running.
  output logic [31:0] excCnt // Exceptions taken.
);
  logic [15:0] left_q;
  logic gap_q;
  assign busy = (left_q != 16'h0000);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 16'h0000;
      gap_q <= 1'b0;
      oscEn <= 1'b0;
    end else if (start) begin
      left_q <= burst;
      oscEn <= 1'b0;
    end else begin
      oscEn <= busy && !gap_q;
      gap_q <= slow && busy && !gap_q;
      if (busy && !gap_q) begin
        left_q <= left_q - 16'h0001;
      end
    end
  end
  // The core takes every pulse as one pended exception.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      excCnt <= 32'h0;
    end else begin
      excCnt <= excCnt + {31'h0, tickExcReq};
    end
  end
endmodule // stk_osc_model

// >>> bench/stk_timer_test.sv
// Purpose: Self-checking bench for the tick down-counter.
// Assumes: Read data in the cycle after the strobe.
// Notes: Reads are noted in a queue and judged by a monitor.
`timescale 1ns/100ps
`include "stk_params.svh"
module stk_timer_test;
  logic sys_clk, rst_b, regWr, regRd, start, slow, oscEn, tickExcReq, busy, rdP1;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, excCnt, rng, e;
  logic [15:0] burst;
  logic [31:0] expQ[$];
  int error_cnt, total_checks;
  stk_timer stk_timer_i (.sys_clk(sys_clk), .rst_b(rst_b), .oscEn(oscEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .tickExcReq(tickExcReq));
  stk_osc_model stk_osc_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .start(start),
    .burst(burst), .slow(slow), .tickExcReq(tickExcReq), .oscEn(oscEn), .busy(busy),
    .excCnt(excCnt));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    expQ.push_back(x);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask
  task automatic osc(input logic [15:0] n, input logic s);
    int i;
    @(posedge sys_clk);
    burst <= n;
    slow <= s;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (i = 0; i < 4000 && (i < 2 || busy !== 1'b0); i++) @(posedge sys_clk);
    if (i >= 4000) begin
      error_cnt++;
      end_of_test();
    end
    repeat (8) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Read monitor
  // ----------------------------------------
  // Read data stand only in the cycle after the strobe, so one stage of delay meets them.
  always @(posedge sys_clk) begin
    if (rdP1 === 1'b1) chk(regRdata, expQ.pop_front());
    rdP1 <= regRd;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, regWr, regRd, start, slow} = 5'h00;
    {regAddr, regWdata, burst} = 60'h0;
    error_cnt = 0;
    total_checks = 0;
    rng = xs(32'd46);
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`STK_OFS_CTRL, 32'h0);
    rd(`STK_OFS_CURRENT, 32'h0);
    rd(`STK_OFS_CALIB, 32'h0);
    wr(12'h020, rng);
    rd(12'h020, 32'h0);
    wr(`STK_OFS_RELOAD, {rng[31:24], 24'h000005});
    rd(`STK_OFS_RELOAD, 32'h5);
    wr(`STK_OFS_CTRL, 32'h3);
    rd(`STK_OFS_CURRENT, 32'h5);
    osc(16'd64, 1'b0);
    rd(`STK_OFS_CURRENT, 32'h3);
    osc(16'd128, 1'b1);
    rd(`STK_OFS_CTRL, 32'h00010003);
    rd(`STK_OFS_CTRL, 32'h3);
    rd(`STK_OFS_CURRENT, 32'h5);
    chk(excCnt, 32'h1);
    wr(`STK_OFS_CTRL, 32'h1);
    osc(16'd192, 1'b0);
    chk(excCnt, 32'h1);
    wr(`STK_OFS_CURRENT, xs(rng));
    rd(`STK_OFS_CURRENT, 32'h0);
    rd(`STK_OFS_CTRL, 32'h1);
    wr(`STK_OFS_RELOAD, 32'h2);
    wr(`STK_OFS_CTRL, 32'h7);
    rd(`STK_OFS_CTRL, 32'h00010007);
    @(negedge sys_clk);
    e = excCnt;
    repeat (30) @(negedge sys_clk);
    chk(excCnt - e, 32'd10);
    // Disabled on the fast source: a cleared count must stay at zero.
    wr(`STK_OFS_CTRL, 32'h4);
    wr(`STK_OFS_CURRENT, rng);
    repeat (8) @(posedge sys_clk);
    rd(`STK_OFS_CURRENT, 32'h0);
    rd(`STK_OFS_CTRL, 32'h4);
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`STK_OFS_RELOAD, 32'h0);
    rd(`STK_OFS_CTRL, 32'h0);
    repeat (4) @(posedge sys_clk);
    end_of_test();
  end
endmodule // stk_timer_test
